/* hw/dcsid_irq_chain.sv */
// Six-source interrupt controller with internal and external daisy chain
`timescale 1ns/1ns
//
// Function
// (RULE_01) Channel B vector read always carries status
// (RULE_02) That status tracks highest pending, not latched; code shows the highest under-service source while one is set
// (RULE_03) Vector read value frozen during the read
// (RULE_04) Removing condition clears pending, drops request
// (RULE_05) After acknowledge settles, mark highest pending served
// (RULE_06) Acknowledge read drives vector unless suppressed
// (RULE_07) Status mode replaces three vector bits
// (RULE_08) Only reset-highest command clears under-service
// (RULE_09) Suppressed vector still serves; status held
// (RULE_10) Two channels, three sources each
// (RULE_11) Receive request on character or special condition
// (RULE_12) Transmit pending only on full-to-empty edge
// (RULE_13) Six individually enabled external conditions
// (RULE_14) Source requests only while enabled
// (RULE_15) All six pending bits readable by software
// (RULE_16) Under-service hidden, masks lower sources
// (RULE_17) Channel A first; receive, transmit, external
// (RULE_18) Request drives open-drain output low
// (RULE_19) Acknowledge gates pending into chain
// (RULE_20) Master enable clear equals chain input low
// (RULE_21) Request only when all gating conditions hold
// (RULE_22) Chain output follows input, blocked during acknowledge
// (RULE_23) Status in bits one-three or four-six
// (RULE_24) Disable-lower bit forces chain output low
// (RULE_25) Suppressed vector leaves data bus undriven
// (RULE_26) Reset command clears only highest under-service
module dcsid_irq_chain #(
    parameter int SETTLE_CYC = dcsid_pkg::ACK_SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Control bits
    input wire dcsid_pkg::dcsid_ctrl_s ctrl_i,
    input wire logic [7:0] vector_base_i,
    input wire logic [dcsid_pkg::NUM_SRC-1:0] source_enable_i,
    input wire logic [1:0] parity_special_en_i,
    input wire logic [1:0][dcsid_pkg::NUM_EXT_COND-1:0] ext_status_enable_i,
    // Commands
    input wire logic reset_ius_i,
    input wire logic soft_reset_i,
    // Source events and clears
    input wire dcsid_pkg::dcsid_rx_ev_s [1:0] rx_ev_i,
    input wire logic [1:0] rx_pending_clear_i,
    input wire logic [1:0] tx_buf_full_i,
    input wire logic [1:0] tx_pending_clear_i,
    input wire logic [1:0][dcsid_pkg::NUM_EXT_COND-1:0] ext_cond_i,
    input wire logic [1:0] ext_pending_clear_i,
    // Processor reads
    input wire logic vec_rd_b_i,
    input wire logic ack_vec_rd_i,
    // Pins
    input wire logic irq_ack_n_i,
    input wire logic chain_enable_in_i,
    output logic irq_oe_o,
    output logic chain_enable_out_o,
    output logic [7:0] data_o,
    output logic data_oe_o,
    // Status
    output logic [7:0] vector_read_data_o,
    output logic [dcsid_pkg::NUM_SRC-1:0] pending_status_o
);
    import dcsid_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic ack_n_s;
    logic chain_in_s;
    logic [NUM_SRC-1:0] pend_r;
    logic [NUM_SRC-1:0] ius_r;
    logic [1:0] rx_spc_r;
    logic [1:0] tx_full_q;
    logic [NUM_SRC-1:0] req;
    logic [NUM_SRC-1:0] ius_mask;
    logic win_found;
    logic [2:0] win_idx;
    logic ius_found;
    logic [2:0] ius_idx;
    logic pend_found;
    logic [2:0] pend_idx;
    logic eff_in;
    logic ack_active;
    logic settle_done;
    logic [2:0] read_code;
    logic [2:0] ack_code_r;
    logic ack_hit_r;
    logic [7:0] cnt_r;
    dcsid_ack_e ack_st_r;
    dcsid_ack_e ack_st_nxt;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Source code by priority index; receive code depends on special state
    function automatic logic [2:0] src_code(input logic [2:0] idx, input logic [1:0] spc);
        logic [2:0] c;
        c = CODE_IDLE;
        case (idx)
            3'h0: c = spc[CH_A] ? CODE_A_SPC : CODE_A_RX;
            3'h1: c = CODE_A_TX;
            3'h2: c = CODE_A_EXT;
            3'h3: c = spc[CH_B] ? CODE_B_SPC : CODE_B_RX;
            3'h4: c = CODE_B_TX;
            3'h5: c = CODE_B_EXT;
            default: c = CODE_IDLE;
        endcase
        return c;
    endfunction

    // Place code in low field or, bit-reversed, in high field
    function automatic logic [7:0] put_code(input logic [7:0] base, input logic [2:0] code, input logic high);
        logic [7:0] v;
        v = base;
        if (high)
        begin
            v[VEC_HI_POS] = code[2];
            v[VEC_HI_POS+1] = code[1];
            v[VEC_HI_POS+2] = code[0];
        end
        else
            v[VEC_LO_POS+2:VEC_LO_POS] = code;
        return v;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    dcsid_sync3 #(.INIT(1'b1)) u_sync_ack (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i(irq_ack_n_i),
        .level_o(ack_n_s)
    );
    dcsid_sync3 #(.INIT(1'b0)) u_sync_chain (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i(chain_enable_in_i),
        .level_o(chain_in_s)
    );

    // ------------------------------------------------------------
    // Internal daisy chain
    // ------------------------------------------------------------
    // Master enable acts as a second chain input
    assign eff_in = chain_in_s & ctrl_i.master_irq_enable; // see RULE_20
    assign ack_active = (ack_st_r != ACK_IDLE);
    assign settle_done = (ack_st_r == ACK_SETTLE) && (cnt_r == 8'(SETTLE_CYC - 1));

    // Any set under-service bit at or above a source blocks it
    always_comb
    begin
        for (int i = 0; i < NUM_SRC; i++)
        begin
            ius_mask[i] = 1'b0;
            for (int j = 0; j <= i; j++)
                ius_mask[i] = ius_mask[i] | ius_r[j]; // see RULE_16
            req[i] = pend_r[i] & source_enable_i[i] & ~ius_mask[i]; // see RULE_14
        end
    end

    // Winner for acknowledge; index order gives channel A first
    dcsid_prio u_prio_win (
        .req_i(req), // see RULE_19
        .found_o(win_found),
        .idx_o(win_idx) // see RULE_17
    );
    dcsid_prio u_prio_ius (
        .req_i(ius_r),
        .found_o(ius_found),
        .idx_o(ius_idx)
    );
    dcsid_prio u_prio_pend (
        .req_i(pend_r),
        .found_o(pend_found),
        .idx_o(pend_idx)
    );

    // ------------------------------------------------------------
    // Pending bits, one per source of each channel
    // ------------------------------------------------------------
    // Previous transmit-full level for edge detection
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tx_full_q <= 2'h0;
        else
            tx_full_q <= tx_buf_full_i;
    end

    // Set wins over clear so an event in the clear cycle is kept
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pend_r <= '0;
            rx_spc_r <= 2'h0;
        end
        else if (soft_reset_i)
        begin
            pend_r <= '0;
            rx_spc_r <= 2'h0;
        end
        else
        begin
            for (int ch = 0; ch < 2; ch++)
            begin : g_ch
                logic spc;
                logic rx_set;
                logic tx_set;
                logic ext_set;
                spc = rx_ev_i[ch].overrun | rx_ev_i[ch].crc_frame_err | rx_ev_i[ch].end_of_frame
                    | (rx_ev_i[ch].parity_err & parity_special_en_i[ch]); // see RULE_11
                rx_set = rx_ev_i[ch].char_avail | spc; // see RULE_11
                tx_set = tx_full_q[ch] & ~tx_buf_full_i[ch]; // see RULE_12
                ext_set = |(ext_cond_i[ch] & ext_status_enable_i[ch]); // see RULE_13
                // Three sources per channel at stride three
                if (rx_set)
                    pend_r[3*ch+SRC_A_RX] <= 1'b1; // see RULE_10
                else if (rx_pending_clear_i[ch])
                    pend_r[3*ch+SRC_A_RX] <= 1'b0; // see RULE_04
                if (spc)
                    rx_spc_r[ch] <= 1'b1;
                else if (rx_pending_clear_i[ch])
                    rx_spc_r[ch] <= 1'b0;
                // Refilling the buffer removes the empty condition
                if (tx_set)
                    pend_r[3*ch+SRC_A_TX] <= 1'b1;
                else if (tx_pending_clear_i[ch] || (tx_buf_full_i[ch] && !tx_full_q[ch]))
                    pend_r[3*ch+SRC_A_TX] <= 1'b0; // see RULE_04
                if (ext_set)
                    pend_r[3*ch+SRC_A_EXT] <= 1'b1;
                else if (ext_pending_clear_i[ch])
                    pend_r[3*ch+SRC_A_EXT] <= 1'b0; // see RULE_04
            end
        end
    end

    // ------------------------------------------------------------
    // Acknowledge sequencer
    // ------------------------------------------------------------
    // Wait for the external chain to settle before choosing a winner
    always_comb
    begin
        ack_st_nxt = ack_st_r;
        unique case (ack_st_r)
            ACK_IDLE: if (!ack_n_s) ack_st_nxt = ACK_SETTLE;
            ACK_SETTLE:
            begin
                if (ack_n_s)
                    ack_st_nxt = ACK_IDLE;
                else if (settle_done)
                    ack_st_nxt = ACK_SERVE; // see RULE_05
            end
            ACK_SERVE: if (ack_n_s) ack_st_nxt = ACK_IDLE;
            default: ack_st_nxt = ACK_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ack_st_r <= ACK_IDLE;
            cnt_r <= 8'h00;
        end
        else
        begin
            ack_st_r <= ack_st_nxt;
            cnt_r <= (ack_st_r == ACK_SETTLE) ? cnt_r + 8'h01 : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Under-service bits
    // ------------------------------------------------------------
    // Only the reset command or a reset clears these; acknowledge sets one
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ius_r <= '0;
            ack_code_r <= CODE_IDLE;
            ack_hit_r <= 1'b0;
        end
        else if (soft_reset_i)
        begin
            ius_r <= '0;
            ack_hit_r <= 1'b0;
        end
        else
        begin
            if (reset_ius_i && ius_found)
                ius_r[ius_idx] <= 1'b0; // see RULE_08 see RULE_26
            if (settle_done)
            begin
                ack_hit_r <= win_found & eff_in;
                ack_code_r <= src_code(win_idx, rx_spc_r);
                if (win_found && eff_in)
                    ius_r[win_idx] <= 1'b1; // see RULE_05 see RULE_19 see RULE_09
            end
        end
    end

    // ------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------
    // Request only with chain input high and no acknowledge running
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            irq_oe_o <= 1'b0;
        else
            irq_oe_o <= eff_in & ~ack_active & (|req); // see RULE_18 see RULE_21
    end

    // Chain output blocks lower devices inside an acknowledge with a source pending or in service, or while disable_lower_chain is set
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            chain_enable_out_o <= 1'b0;
        else if (ctrl_i.disable_lower_chain)
            chain_enable_out_o <= 1'b0; // see RULE_24
        else if (ack_active && (|pend_r || |ius_r))
            chain_enable_out_o <= 1'b0; // see RULE_22
        else
            chain_enable_out_o <= eff_in; // see RULE_22
    end

    // Vector onto the bus only for an acknowledged source, never when suppressed
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            data_o <= VEC_RESET;
            data_oe_o <= 1'b0;
        end
        else
        begin
            data_oe_o <= ack_vec_rd_i & (ack_st_r == ACK_SERVE) & ack_hit_r
                & ~ctrl_i.suppress_vector; // see RULE_06 see RULE_25
            if (ctrl_i.vector_includes_status)
                data_o <= put_code(vector_base_i, ack_code_r, ctrl_i.status_high); // see RULE_07 see RULE_23
            else
                data_o <= vector_base_i;
        end
    end

    // ------------------------------------------------------------
    // Software-visible status
    // ------------------------------------------------------------
    // Served source holds the code so it cannot drift while in service
    assign read_code = ius_found ? src_code(ius_idx, rx_spc_r)
        : (pend_found ? src_code(pend_idx, rx_spc_r) : CODE_IDLE); // see RULE_02 see RULE_09

    // Tracks live status; holding during a read avoids a torn value
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            vector_read_data_o <= VEC_RESET;
        else if (!vec_rd_b_i)
            vector_read_data_o <= put_code(vector_base_i, read_code, ctrl_i.status_high); // see RULE_01 see RULE_03
    end

    // Bit five is the highest-priority source; under-service stays hidden
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pending_status_o <= '0;
        else
            for (int i = 0; i < NUM_SRC; i++)
                pending_status_o[NUM_SRC-1-i] <= pend_r[i]; // see RULE_15
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    ack_blocks_irq_a: assert property (ack_active |=> !irq_oe_o) // see RULE_21
        else $error("interrupt driven during acknowledge");
    dlc_forces_low_a: assert property (ctrl_i.disable_lower_chain |=> !chain_enable_out_o) // see RULE_24
        else $error("chain output high with lower chain disabled");
    nv_floats_bus_a: assert property (ctrl_i.suppress_vector |=> !data_oe_o) // see RULE_25
        else $error("data bus driven with vector suppressed");
    ius_clear_cause_a: assert property ((|($past(ius_r) & ~ius_r)) |-> $past(reset_ius_i || soft_reset_i)) // see RULE_08
        else $error("under-service cleared without command");
    ius_single_set_a: assert property ($countones(ius_r & ~$past(ius_r)) <= 1) // see RULE_19
        else $error("more than one under-service bit set");
    reset_one_ius_a: assert property (reset_ius_i && !soft_reset_i && !settle_done && |ius_r
        |=> $countones(ius_r) == $countones($past(ius_r)) - 1) // see RULE_26
        else $error("reset command cleared wrong number of bits");
    tx_edge_only_a: assert property ($rose(pend_r[SRC_A_TX]) |-> $past(tx_full_q[CH_A] && !tx_buf_full_i[CH_A])) // see RULE_12
        else $error("transmit pending set without full-to-empty edge");
    read_frozen_a: assert property (vec_rd_b_i && $past(vec_rd_b_i) |-> $stable(vector_read_data_o)) // see RULE_03
        else $error("vector read value changed during read");
    irq_needs_en_a: assert property (irq_oe_o |-> $past(|(pend_r & source_enable_i) && eff_in)) // see RULE_14
        else $error("request without enabled pending source");
    settle_wait_a: assert property ($rose(ack_st_r == ACK_SERVE) |-> $past(cnt_r) == 8'(SETTLE_CYC - 1)) // see RULE_05
        else $error("acknowledge served before settle time");

    irq_seen_c: cover property (irq_oe_o ##[1:20] !ack_n_s);
    vec_driven_c: cover property (data_oe_o && ctrl_i.vector_includes_status);
    ius_reset_c: cover property (|ius_r ##1 reset_ius_i ##1 ius_r == '0);
    status_read_c: cover property (vec_rd_b_i [*3]);
endmodule // dcsid_irq_chain

/* hw/dcsid_pkg.sv */
// Shared constants and carriers of the dual channel interrupt daisy chain
package dcsid_pkg;
    // ------------------------------------------------------------
    // Source indices, priority order, index 0 is highest
    // ------------------------------------------------------------
    localparam int NUM_SRC = 6;
    localparam int SRC_A_RX = 0;
    localparam int SRC_A_TX = 1;
    localparam int SRC_A_EXT = 2;
    localparam int SRC_B_RX = 3;
    localparam int SRC_B_TX = 4;
    localparam int SRC_B_EXT = 5;
    localparam int NUM_EXT_COND = 6;
    localparam int CH_A = 0;
    localparam int CH_B = 1;
    // ------------------------------------------------------------
    // Three-bit source codes placed into the vector
    // ------------------------------------------------------------
    localparam logic [2:0] CODE_B_TX = 3'h0;
    localparam logic [2:0] CODE_B_EXT = 3'h1;
    localparam logic [2:0] CODE_B_RX = 3'h2;
    localparam logic [2:0] CODE_B_SPC = 3'h3;
    localparam logic [2:0] CODE_A_TX = 3'h4;
    localparam logic [2:0] CODE_A_EXT = 3'h5;
    localparam logic [2:0] CODE_A_RX = 3'h6;
    localparam logic [2:0] CODE_A_SPC = 3'h7;
    localparam logic [2:0] CODE_IDLE = CODE_B_SPC;
    // Status field positions inside the vector
    localparam int VEC_LO_POS = 1;
    localparam int VEC_HI_POS = 4;
    localparam logic [7:0] VEC_RESET = 8'h00;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int ACK_SETTLE_NS = 200;
    localparam int ACK_SETTLE_CYC = (ACK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic master_irq_enable;
        logic vector_includes_status;
        logic suppress_vector;
        logic disable_lower_chain;
        logic status_high;
    } dcsid_ctrl_s;
    typedef struct packed {
        logic char_avail;
        logic overrun;
        logic crc_frame_err;
        logic end_of_frame;
        logic parity_err;
    } dcsid_rx_ev_s;
    typedef enum logic [2:0] {
        ACK_IDLE = 3'b001,
        ACK_SETTLE = 3'b010,
        ACK_SERVE = 3'b100
    } dcsid_ack_e;
endpackage

/* hw/dcsid_sync3.sv */
// Three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ns
module dcsid_sync3 #(
    parameter logic INIT = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Pin and clean level
    input wire logic pin_i,
    output logic level_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // First stage feeds only the second; a change counts once stages two and three agree
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            level_o <= INIT;
        end
        else
        begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                level_o <= s3_r;
        end
    end
endmodule // dcsid_sync3

/* hw/dcsid_prio.sv */
// Fixed-priority picker over the six interrupt sources
`timescale 1ns/1ns
module dcsid_prio (
    // Requests, bit 0 highest
    input wire logic [dcsid_pkg::NUM_SRC-1:0] req_i,
    // Winner
    output logic found_o,
    output logic [2:0] idx_o
);
    import dcsid_pkg::*;

    // Scan from the lowest priority up so the lowest-numbered set bit wins
    always_comb
    begin
        found_o = 1'b0;
        idx_o = 3'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (req_i[i])
            begin
                found_o = 1'b1;
                idx_o = 3'(i);
            end
        end
    end
endmodule // dcsid_prio

/* sim/dcsid_host.sv */
// Host processor model: acknowledge pin, chain input and vector read strobe
`timescale 1ns/1ns
module dcsid_host (
    // Clock and interrupt line
    input wire logic clk_sys_i,
    input wire logic irq_n_i,
    // Data bus seen by the host
    input wire logic [7:0] data_i,
    input wire logic data_oe_i,
    // Driven pins
    output logic irq_ack_n_o,
    output logic chain_enable_in_o,
    output logic ack_vec_rd_o
);
    // --------------------------------------------------------
    // Idle levels; no higher device upstream, so chain input high
    // --------------------------------------------------------
    initial
    begin
        irq_ack_n_o = 1'b1;
        chain_enable_in_o = 1'b1;
        ack_vec_rd_o = 1'b0;
    end

    // Wait for the request, then acknowledge; bounded so a dead line cannot hang
    task automatic begin_ack();
        int n;
        n = 0;
        while (irq_n_i !== 1'b0 && n < 50)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        irq_ack_n_o = 1'b0;
        repeat (8) @(negedge clk_sys_i);
    endtask

    // Vector read held until sampled, then pin and strobe released together
    task automatic finish_ack(output logic [7:0] vec, output logic oe);
        ack_vec_rd_o = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        oe = data_oe_i;
        vec = oe ? data_i : ~data_i;
        ack_vec_rd_o = 1'b0;
        irq_ack_n_o = 1'b1;
        @(negedge clk_sys_i);
    endtask
endmodule // dcsid_host

/* sim/tb_dual_channel_serial_irq_daisy_chain.sv */
// Testbench of the dual channel interrupt daisy chain
`timescale 1ns/1ns
module tb_dual_channel_serial_irq_daisy_chain;
    import dcsid_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    dcsid_ctrl_s ctrl = '0;
    logic [5:0] src_en = 6'h3F;
    logic [1:0][5:0] ext_en = '0;
    logic [1:0][5:0] ext_cond = '0;
    dcsid_rx_ev_s [1:0] rx_ev = '0;
    logic [1:0] tx_full = 2'h0;
    logic [1:0] tx_clr = 2'h0;
    logic [1:0] ext_clr = 2'h0;
    logic [1:0] rx_clr = 2'h0;
    logic reset_ius = 1'b0;
    logic vrd_b = 1'b0;
    logic ack_n, chain_in, ack_rd, irq_oe, chain_out, data_oe, oe;
    logic [7:0] data, vrd, vec;
    logic [5:0] pend;
    int fails = 0;
    int n_tests = 0;

    // ------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------
    initial
    begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    dcsid_irq_chain #(.SETTLE_CYC(2)) i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ctrl_i(ctrl),
        .vector_base_i(8'h81), .source_enable_i(src_en), .parity_special_en_i(2'h0),
        .ext_status_enable_i(ext_en), .reset_ius_i(reset_ius), .soft_reset_i(1'b0), .rx_ev_i(rx_ev),
        .rx_pending_clear_i(rx_clr), .tx_buf_full_i(tx_full), .tx_pending_clear_i(tx_clr),
        .ext_cond_i(ext_cond), .ext_pending_clear_i(ext_clr), .vec_rd_b_i(vrd_b), .ack_vec_rd_i(ack_rd),
        .irq_ack_n_i(ack_n), .chain_enable_in_i(chain_in), .irq_oe_o(irq_oe), .chain_enable_out_o(chain_out),
        .data_o(data), .data_oe_o(data_oe), .vector_read_data_o(vrd), .pending_status_o(pend));

    // Open-drain line low while the design drives it
    dcsid_host i_host (.clk_sys_i(clk_sys_i), .irq_n_i(~irq_oe), .data_i(data), .data_oe_i(data_oe),
        .irq_ack_n_o(ack_n), .chain_enable_in_o(chain_in), .ack_vec_rd_o(ack_rd));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task step(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog well beyond the roughly 125 cycles the sequence needs
    initial
    begin
        repeat (5000) @(posedge clk_sys_i);
        fails++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        ctrl.master_irq_enable = 1'b1;
        ext_en[0] = 6'h3F;
        step(16);
        rst_n_i = 1'b1;
        chk(8'(irq_oe), 8'h00);
        tx_full[0] = 1'b1;
        step(3);
        chk(8'(pend), 8'h00);
        tx_full[0] = 1'b0;
        step(3);
        chk(8'(pend), 8'h10);
        chk(8'(irq_oe), 8'h01);
        // Three sources at once: A tx wins over A ext and B rx
        rx_ev[1].char_avail = 1'b1;
        ext_cond[0][1] = 1'b1;
        step(1);
        rx_ev[1].char_avail = 1'b0;
        ext_cond[0][1] = 1'b0;
        step(3);
        chk(8'(pend), 8'h1C);
        chk(vrd, 8'h89);
        tx_clr[0] = 1'b1;
        step(1);
        tx_clr[0] = 1'b0;
        step(3);
        chk(vrd, 8'h8B);
        // Held read must not move when the source is cleared underneath
        vrd_b = 1'b1;
        ext_clr[0] = 1'b1;
        step(1);
        ext_clr[0] = 1'b0;
        step(3);
        chk(vrd, 8'h8B);
        vrd_b = 1'b0;
        step(2);
        chk(vrd, 8'h85);
        chk(8'(irq_oe), 8'h01);
        chk(8'(chain_out), 8'h01);
        src_en = 6'h00;
        step(3);
        chk(8'(irq_oe), 8'h00);
        src_en = 6'h3F;
        ctrl.master_irq_enable = 1'b0;
        step(3);
        chk(8'(irq_oe), 8'h00);
        ctrl.master_irq_enable = 1'b1;
        ctrl.disable_lower_chain = 1'b1;
        step(3);
        chk(8'(chain_out), 8'h00);
        ctrl.disable_lower_chain = 1'b0;
        // Acknowledge with status in the low then the high field
        ctrl.vector_includes_status = 1'b1;
        for (int sh = 0; sh < 2; sh++)
        begin
            ctrl.status_high = sh[0];
            i_host.begin_ack();
            chk(8'(irq_oe), 8'h00);
            chk(8'(chain_out), 8'h00);
            i_host.finish_ack(vec, oe);
            chk(8'(oe), 8'h01);
            chk(vec, sh ? 8'hA1 : 8'h85);
            // Let the released acknowledge clear the synchroniser, so only the mask holds the line
            step(5);
            chk(8'(irq_oe), 8'h00);
            reset_ius = 1'b1;
            step(1);
            reset_ius = 1'b0;
            step(3);
            chk(8'(irq_oe), 8'h01);
        end
        // Suppressed vector: bus left alone, status held until reset command
        ctrl.suppress_vector = 1'b1;
        ctrl.status_high = 1'b0;
        i_host.begin_ack();
        i_host.finish_ack(vec, oe);
        chk(8'(oe), 8'h00);
        rx_ev[0].char_avail = 1'b1;
        step(1);
        rx_ev[0].char_avail = 1'b0;
        step(3);
        chk(vrd, 8'h85);
        // Nested service: A receive is taken while B receive stays in service
        i_host.begin_ack();
        i_host.finish_ack(vec, oe);
        step(5);
        chk(vrd, 8'h8D);
        reset_ius = 1'b1;
        step(1);
        reset_ius = 1'b0;
        step(3);
        chk(vrd, 8'h85);
        reset_ius = 1'b1;
        step(1);
        reset_ius = 1'b0;
        step(3);
        chk(vrd, 8'h8D);
        end_of_test();
    end
endmodule // tb_dual_channel_serial_irq_daisy_chain
